// >>> dv/phy_link_model.sv
// Purpose: link status of the two redundant physical ports
// Assumes: links report up unless the bench cuts them
// Notes: status changes one edge after the cut request
module phy_link_model (
    input wire logic clock_i, // clock
    input wire logic reset_i, // reset
    input wire logic [1:0] cut_i, // bit 0 second port, bit 1 third
    output logic link_p2_o, // second port link up
    output logic link_p3_o // third port link up
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clock_i) begin
        link_p2_o <= reset_i | ~cut_i[0];
        link_p3_o <= reset_i | ~cut_i[1];
    end
endmodule // phy_link_model

// >>> dv/selftest_failover_monitor.sv
// Purpose: port-level assertions for the failover block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to the design top from the testbench file
`include "selftest_failover_cfg.svh"
module selftest_failover_monitor (
    input wire logic clock_i, // clock
    input wire logic reset_i, // reset
    input wire logic time_server_fail_check_i, // raw check
    input wire logic time_server_alarm_o, // gated alarm
    input wire logic major_alarm_o, // major alarm
    input wire logic out_of_service_o, // out of service
    input wire logic [`IP_W-1:0] p2_ip_i, // second port ip
    input wire logic [`HW_ADDR_W-1:0] hw_addr_p2_o, // address
    input wire logic [`HW_ADDR_W-1:0] hw_addr_p3_o, // address
    input wire logic [`IP_W-1:0] eff_p3_ip_o, // applied ip
    input wire logic shared_mode_o, // mode
    input wire logic p2_enable_o, // enable
    input wire logic p3_enable_o, // enable
    input wire logic active_port_o, // active port
    input wire logic link_p2_i, // link
    input wire logic link_p3_i, // link
    input wire logic goose_tx_i, // goose request
    input wire logic goose_tx_p2_o, // goose out
    input wire logic goose_tx_p3_o, // goose out
    input wire logic bcast_p2_o, // broadcast
    input wire logic bcast_p3_o // broadcast
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    // ------------------------------------------------
    // failover steps
    // ------------------------------------------------
    sequence s_lost_p2;
        shared_mode_o && !active_port_o && !link_p2_i && link_p3_i;
    endsequence
    sequence s_on_p3;
        active_port_o && p3_enable_o && !p2_enable_o;
    endsequence
    sequence s_p2_back;
        shared_mode_o && active_port_o && link_p2_i;
    endsequence
    sequence s_on_p2;
        !active_port_o && p2_enable_o && !p3_enable_o;
    endsequence
    a_alarm_gate_raw:
    assert property ($rose(time_server_alarm_o) |->
        $past(time_server_fail_check_i))
        else $error("alarm rose without raw failure");
    a_major_oos:
    assert property (out_of_service_o == major_alarm_o)
        else $error("out of service differs from major alarm");
    a_addr_step:
    assert property (!$past(reset_i) |->
        hw_addr_p3_o == hw_addr_p2_o + 48'h1)
        else $error("third address not second plus one");
    a_shared_ip_copy:
    assert property (shared_mode_o && $past(shared_mode_o) |->
        eff_p3_ip_o == $past(p2_ip_i))
        else $error("third ip not taken from second port");
    a_one_active:
    assert property (shared_mode_o && $past(shared_mode_o, 2) |->
        p2_enable_o != p3_enable_o)
        else $error("shared mode without exactly one port");
    a_failover_fast:
    assert property (s_lost_p2 |-> ##[1:2] s_on_p3)
        else $error("failover to third port too slow");
    a_revert_prompt:
    assert property (s_p2_back |-> ##[1:2] s_on_p2)
        else $error("no revert to second port");
    a_bcast_standby:
    assert property ($rose(active_port_o) |-> bcast_p3_o ##1 !bcast_p3_o)
        else $error("no single broadcast on third port");
    a_bcast_primary:
    assert property ($fell(active_port_o) && shared_mode_o |-> bcast_p2_o)
        else $error("no broadcast on second port");
    a_goose_both:
    assert property (!shared_mode_o && !$past(shared_mode_o, 2) &&
        $past(goose_tx_i) |-> goose_tx_p2_o && goose_tx_p3_o)
        else $error("goose not sent on both ports");
endmodule // selftest_failover_monitor

// >>> dv/selftest_mask_port_failover_tb.sv
// Purpose: self-checking bench for the failover block
// Assumes: 20 MHz clock, reset held three cycles
// Notes: inputs change by non-blocking assignment on rising edges
`include "selftest_failover_cfg.svh"
module selftest_mask_port_failover_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, reset_i, cfg_load_i, mode_save_i, shared_address_mode_i;
    logic peer_absent_en_i, time_server_en_i, time_code_en_i, goose_tx_i;
    logic peer_absent_raw_i, time_server_fail_check_i, time_code_fail_check_i;
    logic goose_rx_p2_i, goose_rx_p3_i, link_p2_i, link_p3_i, goose_rx_o;
    logic [2:0] eth_fail_en_i, eth_fail_raw_i, eth_fail_alarm_o;
    logic [`OPERAND_SEL_W-1:0] operand_sel_i;
    logic [`OPERAND_CNT-1:0] operands_i;
    logic [`HW_ADDR_W-1:0] base_hw_addr_i, hw_addr_p2_o, hw_addr_p3_o;
    logic [`HW_ADDR_W-1:0] src_addr_p3_o;
    logic [`IP_W-1:0] p2_ip_i, p2_mask_i, p2_gw_i, p3_ip_i, p3_mask_i;
    logic [`IP_W-1:0] p3_gw_i, eff_p3_ip_o, eff_p3_mask_o, eff_p3_gw_o;
    logic peer_absent_alarm_o, time_server_alarm_o, time_code_alarm_o;
    logic major_alarm_o, out_of_service_o, shared_mode_o, p2_enable_o;
    logic p3_enable_o, active_port_o, goose_tx_p2_o, goose_tx_p3_o;
    logic bcast_p2_o, bcast_p3_o;
    logic [1:0] cut;
    int n_errors = 0;
    int n_tests = 0;

    selftest_mask_port_failover u_dut (.*);
    phy_link_model u_phy (.clock_i(clock_i), .reset_i(reset_i),
        .cut_i(cut), .link_p2_o(link_p2_i), .link_p3_o(link_p3_i));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    task automatic check(input string name, input logic [63:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    // bounded wait for the switchover broadcast
    task automatic wait_bc(input logic third);
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            if ((third ? bcast_p3_o : bcast_p2_o) === 1'b1) break;
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_defaults();
        @(posedge clock_i);
        {peer_absent_raw_i, time_server_fail_check_i} <= 2'h3;
        time_code_fail_check_i <= 1'b1;
        eth_fail_raw_i <= 3'h7;
        operands_i <= 16'hffff;
        cyc(1);
        check("peer", peer_absent_alarm_o, 1'b1);
        check("tsrv", time_server_alarm_o, 1'b1);
        check("tcode", time_code_alarm_o, 1'b1);
        check("eth", eth_fail_alarm_o, 3'h0);
        check("major", major_alarm_o, 1'b0);
        check("mode", shared_mode_o, 1'b0);
        check("act", active_port_o, 1'b0);
    endtask

    task automatic t_mask();
        @(posedge clock_i);
        cfg_load_i <= 1'b1;
        {peer_absent_en_i, time_server_en_i, time_code_en_i} <= 3'h0;
        eth_fail_en_i <= 3'h5;
        operand_sel_i <= 4'h5;
        @(posedge clock_i);
        cfg_load_i <= 1'b0;
        cyc(1);
        check("peer", peer_absent_alarm_o, 1'b0);
        check("tsrv", time_server_alarm_o, 1'b0);
        check("tcode", time_code_alarm_o, 1'b0);
        check("eth", eth_fail_alarm_o, 3'h5);
        check("major", major_alarm_o, 1'b1);
        check("oos", out_of_service_o, 1'b1);
        @(posedge clock_i);
        operands_i <= 16'hffdf;
        eth_fail_raw_i <= 3'h2;
        cyc(1);
        check("eth", eth_fail_alarm_o, 3'h0);
        check("major", major_alarm_o, 1'b0);
        check("oos", out_of_service_o, 1'b0);
    endtask

    task automatic t_separate();
        @(posedge clock_i);
        {goose_tx_i, goose_rx_p3_i} <= 2'h3;
        cyc(1);
        check("p2hw", hw_addr_p2_o, base_hw_addr_i + 48'h1);
        check("p3hw", hw_addr_p3_o, base_hw_addr_i + 48'h2);
        check("src3", src_addr_p3_o, base_hw_addr_i + 48'h2);
        check("ip3", eff_p3_ip_o, p3_ip_i);
        check("mask3", eff_p3_mask_o, p3_mask_i);
        check("gtx", {goose_tx_p2_o, goose_tx_p3_o}, 2'h3);
        check("grx", goose_rx_o, 1'b1);
        @(posedge clock_i);
        {goose_tx_i, goose_rx_p3_i, goose_rx_p2_i} <= 3'h1;
        cyc(1);
        check("grx2", goose_rx_o, 1'b1);
        check("gtx0", {goose_tx_p2_o, goose_tx_p3_o}, 2'h0);
        @(posedge clock_i);
        goose_rx_p2_i <= 1'b0;
    endtask

    task automatic t_shared();
        @(posedge clock_i);
        {shared_address_mode_i, mode_save_i} <= 2'h3;
        @(posedge clock_i);
        mode_save_i <= 1'b0;
        @(negedge clock_i);
        check("mode", shared_mode_o, 1'b1);
        cyc(2);
        check("ip3", eff_p3_ip_o, p2_ip_i);
        check("gw3", eff_p3_gw_o, p2_gw_i);
        check("src3", src_addr_p3_o, base_hw_addr_i + 48'h1);
        check("ens", {p2_enable_o, p3_enable_o}, 2'h2);
    endtask

    task automatic t_failover();
        @(posedge clock_i);
        cut <= 2'h1;
        wait_bc(1'b1);
        check("bc3", bcast_p3_o, 1'b1);
        check("act", active_port_o, 1'b1);
        check("ens", {p2_enable_o, p3_enable_o}, 2'h1);
        cyc(1);
        check("bc3", bcast_p3_o, 1'b0);
        @(posedge clock_i);
        cut <= 2'h2;
        wait_bc(1'b0);
        check("bc2", bcast_p2_o, 1'b1);
        check("act", active_port_o, 1'b0);
        @(posedge clock_i);
        cut <= 2'h3;
        cyc(6);
        check("act", active_port_o, 1'b0);
        @(posedge clock_i);
        {shared_address_mode_i, mode_save_i} <= 2'h1;
        @(posedge clock_i);
        mode_save_i <= 1'b0;
        cyc(1);
        check("mode", shared_mode_o, 1'b0);
        check("ens", {p2_enable_o, p3_enable_o}, 2'h3);
    endtask

    initial begin
        reset_i = 1'b1;
        {cfg_load_i, mode_save_i, shared_address_mode_i, goose_tx_i} = 4'h0;
        {peer_absent_en_i, time_server_en_i, time_code_en_i} = 3'h7;
        {peer_absent_raw_i, time_server_fail_check_i} = 2'h0;
        {time_code_fail_check_i, goose_rx_p2_i, goose_rx_p3_i} = 3'h0;
        {eth_fail_en_i, eth_fail_raw_i, operand_sel_i} = 10'h0;
        operands_i = 16'h0000;
        cut = 2'h0;
        base_hw_addr_i = 48'h12ff_ffff_fffe;
        {p2_ip_i, p3_ip_i} = {32'hc0a8_fcfc, 32'hc0a8_fdfd};
        {p2_mask_i, p3_mask_i} = {32'hffff_ff00, 32'hffff_0000};
        {p2_gw_i, p3_gw_i} = {32'h0a00_0001, 32'h0a00_0002};
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        t_defaults();
        t_mask();
        t_separate();
        t_shared();
        t_failover();
        end_sim();
    end

    initial begin
        repeat (2000) @(posedge clock_i);
        n_errors++;
        $display("watchdog expired");
        end_sim();
    end
endmodule // selftest_mask_port_failover_tb

bind selftest_mask_port_failover selftest_failover_monitor u_mon (
    .clock_i(clock_i), .reset_i(reset_i),
    .time_server_fail_check_i(time_server_fail_check_i),
    .time_server_alarm_o(time_server_alarm_o),
    .major_alarm_o(major_alarm_o), .out_of_service_o(out_of_service_o),
    .p2_ip_i(p2_ip_i), .hw_addr_p2_o(hw_addr_p2_o),
    .hw_addr_p3_o(hw_addr_p3_o), .eff_p3_ip_o(eff_p3_ip_o),
    .shared_mode_o(shared_mode_o), .p2_enable_o(p2_enable_o),
    .p3_enable_o(p3_enable_o), .active_port_o(active_port_o),
    .link_p2_i(link_p2_i), .link_p3_i(link_p3_i), .goose_tx_i(goose_tx_i),
    .goose_tx_p2_o(goose_tx_p2_o), .goose_tx_p3_o(goose_tx_p3_o),
    .bcast_p2_o(bcast_p2_o), .bcast_p3_o(bcast_p3_o));

// >>> verilog/announce_beacon.sv
// Purpose: issue one broadcast request on the newly active port
// Assumes: frame builder accepts a one-cycle request per port
// Notes: request leaves from a flip-flop the cycle after start
module announce_beacon (
    input wire logic clock_i, // system clock
    input wire logic reset_i, // synchronous reset
    announce_if.gen ann, // request from failover control
    output logic bcast_p2_o, // broadcast request, second port
    output logic bcast_p3_o // broadcast request, third port
);
    logic p2_q;
    logic p3_q;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            p2_q <= 1'b0;
            p3_q <= 1'b0;
        end else begin
            p2_q <= ann.start & ~ann.port;
            p3_q <= ann.start & ann.port;
        end
    end

    assign bcast_p2_o = p2_q;
    assign bcast_p3_o = p3_q;
endmodule // announce_beacon

// >>> verilog/announce_if.sv
// Purpose: switchover announce handshake between failover top and beacon
// Assumes: single clock
// Notes: start is a one-cycle pulse, port tells where to send
interface announce_if;
    logic start;
    logic port;
    modport ctrl (output start, output port);
    modport gen (input start, input port);
endinterface

// >>> verilog/selftest_failover_cfg.svh
// Purpose: constants for the self-test mask and port failover block
// Assumes: 20 MHz clock
// Notes: reset values, field widths and timing counts
`ifndef SELFTEST_FAILOVER_CFG_SVH
`define SELFTEST_FAILOVER_CFG_SVH

// -----------------------------------------------------------------------
// clock and timing
// -----------------------------------------------------------------------
`define CLK_FREQ_HZ 20000000
`define FAILOVER_MAX_MS 10
`define FAILOVER_MAX_CYC ((`CLK_FREQ_HZ / 1000) * `FAILOVER_MAX_MS)
`define FAILOVER_TGT_CYC 2

// -----------------------------------------------------------------------
// widths
// -----------------------------------------------------------------------
`define HW_ADDR_W 48
`define IP_W 32
`define OPERAND_SEL_W 4
`define OPERAND_CNT 16
`define ETH_PORTS 3

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define RST_PEER_ABSENT_EN 1'b1
`define RST_TIME_SERVER_EN 1'b1
`define RST_TIME_CODE_EN 1'b1
`define RST_ETH_FAIL_EN 3'h0
`define RST_OPERAND_SEL 4'h0
`define OPERAND_OFF_IDX 4'h0
`define RST_MODE_SEPARATE 1'b1

`endif

// >>> verilog/selftest_failover_pkg.sv
// Purpose: types shared by the failover block
// Assumes: nothing
// Notes: constants live in selftest_failover_cfg.svh
package selftest_failover_pkg;
    typedef enum logic [0:0] {
        PORT_PRIMARY = 1'b0,
        PORT_STANDBY = 1'b1
    } active_port_e;

    typedef enum logic [1:0] {
        FO_RESET = 2'b00,
        FO_PRIMARY = 2'b01,
        FO_STANDBY = 2'b10
    } failover_state_e;
endpackage

// >>> verilog/selftest_mask_port_failover.sv
// Purpose: self-test alarm gating and redundant ethernet port failover
// Assumes: link status inputs are synchronous to clock_i
// Notes: settings are plain ports, captured on the cfg_load_i and mode_save_i pulses
//
// Behaviour
// - optional minor alarms pass only when enabled
// - peer, time alarms enabled; port alarms disabled
// - major alarm follows selected operand, default off
// - major alarm takes relay out of service
// - port hardware addresses increment by one
// - shared mode uses second port parameters twice
// - shared mode fails over on link loss
// - failover completes well under ten milliseconds
// - revert to second port when link returns
// - broadcast on new port at each switchover
// - separate mode: each port own parameters
// - separate mode: GOOSE sent both, accepted either
// - shared mode: one active port, second address
// - default separate mode, change acts immediately
`include "selftest_failover_cfg.svh"

module selftest_mask_port_failover (
    input wire logic clock_i, // system clock, 20 MHz
    input wire logic reset_i, // synchronous reset, active high
    // ---- self-test settings and raw checks ----
    input wire logic cfg_load_i, // pulse: load enable settings
    input wire logic peer_absent_en_i, // remote peer check enable
    input wire logic [2:0] eth_fail_en_i, // per-port failure enables
    input wire logic time_server_en_i, // time server check enable
    input wire logic time_code_en_i, // time code check enable
    input wire logic [`OPERAND_SEL_W-1:0] operand_sel_i, // major operand
    input wire logic [`OPERAND_CNT-1:0] operands_i, // user logic operands
    input wire logic peer_absent_raw_i, // remote peer absent
    input wire logic [2:0] eth_fail_raw_i, // per-port failure
    input wire logic time_server_fail_check_i, // time server failure
    input wire logic time_code_fail_check_i, // time code failure
    output logic peer_absent_alarm_o, // gated alarm
    output logic [2:0] eth_fail_alarm_o, // gated alarms
    output logic time_server_alarm_o, // gated alarm
    output logic time_code_alarm_o, // gated alarm
    output logic major_alarm_o, // configurable major alarm
    output logic out_of_service_o, // relay removed from service
    // ---- redundancy ----
    input wire logic shared_address_mode_i, // 1: shared, 0: separate
    input wire logic mode_save_i, // pulse: save mode selection
    input wire logic [`HW_ADDR_W-1:0] base_hw_addr_i, // first port address
    input wire logic [`IP_W-1:0] p2_ip_i, // second port ip
    input wire logic [`IP_W-1:0] p2_mask_i, // second port mask
    input wire logic [`IP_W-1:0] p2_gw_i, // second port gateway
    input wire logic [`IP_W-1:0] p3_ip_i, // third port ip
    input wire logic [`IP_W-1:0] p3_mask_i, // third port mask
    input wire logic [`IP_W-1:0] p3_gw_i, // third port gateway
    input wire logic link_p2_i, // second port link up
    input wire logic link_p3_i, // third port link up
    input wire logic goose_tx_i, // GOOSE frame to send
    input wire logic goose_rx_p2_i, // GOOSE received on second port
    input wire logic goose_rx_p3_i, // GOOSE received on third port
    output logic [`HW_ADDR_W-1:0] hw_addr_p2_o, // second port hw address
    output logic [`HW_ADDR_W-1:0] hw_addr_p3_o, // third port hw address
    output logic [`HW_ADDR_W-1:0] src_addr_p3_o, // third port source addr
    output logic [`IP_W-1:0] eff_p3_ip_o, // applied third port ip
    output logic [`IP_W-1:0] eff_p3_mask_o, // applied third port mask
    output logic [`IP_W-1:0] eff_p3_gw_o, // applied third port gateway
    output logic shared_mode_o, // mode in force
    output logic p2_enable_o, // second port carries traffic
    output logic p3_enable_o, // third port carries traffic
    output logic active_port_o, // 0: second, 1: third
    output logic goose_tx_p2_o, // GOOSE send, second port
    output logic goose_tx_p3_o, // GOOSE send, third port
    output logic goose_rx_o, // GOOSE accepted
    output logic bcast_p2_o, // switchover broadcast, second port
    output logic bcast_p3_o // switchover broadcast, third port
);
    import selftest_failover_pkg::*;

    // -------------------------------------------------------------------
    // self-test enables and alarm gating
    // -------------------------------------------------------------------
    logic peer_en_q;
    logic [2:0] eth_en_q;
    logic ts_en_q;
    logic tc_en_q;
    logic [`OPERAND_SEL_W-1:0] sel_q;
    logic peer_alarm_q;
    logic [2:0] eth_alarm_q;
    logic ts_alarm_q;
    logic tc_alarm_q;
    logic major_q;
    logic oos_q;
    logic operand_on;

    // index zero is the constant-off source
    assign operand_on = (sel_q == `OPERAND_OFF_IDX) ? 1'b0
                        : operands_i[sel_q];

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            peer_en_q <= `RST_PEER_ABSENT_EN;
            eth_en_q <= `RST_ETH_FAIL_EN;
            ts_en_q <= `RST_TIME_SERVER_EN;
            tc_en_q <= `RST_TIME_CODE_EN;
            sel_q <= `RST_OPERAND_SEL;
        end else if (cfg_load_i) begin
            peer_en_q <= peer_absent_en_i;
            eth_en_q <= eth_fail_en_i;
            ts_en_q <= time_server_en_i;
            tc_en_q <= time_code_en_i;
            sel_q <= operand_sel_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            peer_alarm_q <= 1'b0;
            eth_alarm_q <= 3'h0;
            ts_alarm_q <= 1'b0;
            tc_alarm_q <= 1'b0;
            major_q <= 1'b0;
            oos_q <= 1'b0;
        end else begin
            peer_alarm_q <= peer_en_q & peer_absent_raw_i;
            eth_alarm_q <= eth_en_q & eth_fail_raw_i;
            ts_alarm_q <= ts_en_q & time_server_fail_check_i;
            tc_alarm_q <= tc_en_q & time_code_fail_check_i;
            major_q <= operand_on;
            oos_q <= operand_on;
        end
    end

    assign peer_absent_alarm_o = peer_alarm_q;
    assign eth_fail_alarm_o = eth_alarm_q;
    assign time_server_alarm_o = ts_alarm_q;
    assign time_code_alarm_o = tc_alarm_q;
    assign major_alarm_o = major_q;
    assign out_of_service_o = oos_q;

    // -------------------------------------------------------------------
    // addresses and applied network parameters
    // -------------------------------------------------------------------
    logic shared_q;
    logic [`HW_ADDR_W-1:0] hw2_q;
    logic [`HW_ADDR_W-1:0] hw3_q;
    logic [`HW_ADDR_W-1:0] src3_q;
    logic [`IP_W-1:0] ip3_q;
    logic [`IP_W-1:0] mask3_q;
    logic [`IP_W-1:0] gw3_q;
    logic [`HW_ADDR_W-1:0] hw2_d;
    logic [`HW_ADDR_W-1:0] hw3_d;

    function automatic logic [`HW_ADDR_W-1:0] next_addr(
        input logic [`HW_ADDR_W-1:0] a
    );
        next_addr = a + `HW_ADDR_W'(1);
    endfunction

    assign hw2_d = next_addr(base_hw_addr_i);
    assign hw3_d = next_addr(hw2_d);

    // mode takes effect on the save pulse, no restart needed
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            shared_q <= ~`RST_MODE_SEPARATE;
        end else if (mode_save_i) begin
            shared_q <= shared_address_mode_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            hw2_q <= '0;
            hw3_q <= '0;
            src3_q <= '0;
            ip3_q <= '0;
            mask3_q <= '0;
            gw3_q <= '0;
        end else begin
            hw2_q <= hw2_d;
            hw3_q <= hw3_d;
            src3_q <= shared_q ? hw2_d : hw3_d;
            ip3_q <= shared_q ? p2_ip_i : p3_ip_i;
            mask3_q <= shared_q ? p2_mask_i : p3_mask_i;
            gw3_q <= shared_q ? p2_gw_i : p3_gw_i;
        end
    end

    assign hw_addr_p2_o = hw2_q;
    assign hw_addr_p3_o = hw3_q;
    assign src_addr_p3_o = src3_q;
    assign eff_p3_ip_o = ip3_q;
    assign eff_p3_mask_o = mask3_q;
    assign eff_p3_gw_o = gw3_q;
    assign shared_mode_o = shared_q;

    // -------------------------------------------------------------------
    // failover state machine
    // -------------------------------------------------------------------
    failover_state_e state_q;
    failover_state_e state_d;
    logic go_standby;
    logic go_primary;
    logic p2_en_q;
    logic p3_en_q;
    logic act_q;

    // both links are watched while on the second port, only the second link while on the third; one cycle to switch
    assign go_standby = (state_q == FO_PRIMARY) & ~link_p2_i
                        & link_p3_i;
    assign go_primary = (state_q == FO_STANDBY) & link_p2_i;

    always_comb begin
        state_d = state_q;
        case (state_q)
            FO_RESET: begin
                state_d = FO_PRIMARY;
            end
            FO_PRIMARY: begin
                if (go_standby) begin
                    state_d = FO_STANDBY;
                end
            end
            FO_STANDBY: begin
                if (go_primary) begin
                    state_d = FO_PRIMARY;
                end
            end
            default: begin
                state_d = FO_RESET;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= FO_RESET;
        end else if (!shared_q) begin
            state_q <= FO_PRIMARY;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            p2_en_q <= 1'b1;
            p3_en_q <= 1'b1;
            act_q <= PORT_PRIMARY;
        end else if (!shared_q) begin
            p2_en_q <= 1'b1;
            p3_en_q <= 1'b1;
            act_q <= PORT_PRIMARY;
        end else begin
            p2_en_q <= (state_d != FO_STANDBY);
            p3_en_q <= (state_d == FO_STANDBY);
            act_q <= (state_d == FO_STANDBY);
        end
    end

    assign p2_enable_o = p2_en_q;
    assign p3_enable_o = p3_en_q;
    assign active_port_o = act_q;

    // -------------------------------------------------------------------
    // GOOSE steering
    // -------------------------------------------------------------------
    logic gtx2_q;
    logic gtx3_q;
    logic grx_q;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            gtx2_q <= 1'b0;
            gtx3_q <= 1'b0;
            grx_q <= 1'b0;
        end else begin
            gtx2_q <= goose_tx_i & p2_en_q;
            gtx3_q <= goose_tx_i & p3_en_q;
            grx_q <= (goose_rx_p2_i & p2_en_q)
                     | (goose_rx_p3_i & p3_en_q);
        end
    end

    assign goose_tx_p2_o = gtx2_q;
    assign goose_tx_p3_o = gtx3_q;
    assign goose_rx_o = grx_q;

    // -------------------------------------------------------------------
    // switchover announcement
    // -------------------------------------------------------------------
    announce_if ann ();

    assign ann.start = shared_q & (go_standby | go_primary);
    assign ann.port = go_standby;

    announce_beacon u_beacon (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ann(ann),
        .bcast_p2_o(bcast_p2_o),
        .bcast_p3_o(bcast_p3_o)
    );
endmodule // selftest_mask_port_failover
